// file: design/ddc_sync_consts.svh
`ifndef DDC_SYNC_CONSTS_SVH
`define DDC_SYNC_CONSTS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_SYNC_GATE_CONTROL 13'h100
`define OFS_MIXER_EIGHTH_RATE_CONTROL 13'h101
`define OFS_FILTER_OUTPUT_MODE_CONTROL 13'h102
`define OFS_HALFBAND_FILTER_CONTROL 13'h103
`define OFS_MONITOR_PERIOD_BYTE0 13'h113
`define OFS_MONITOR_PERIOD_BYTE1 13'h114
`define OFS_MONITOR_PERIOD_BYTE2 13'h115
`define OFS_MONITOR_RESULT_A_BYTE0 13'h116
`define OFS_MONITOR_RESULT_A_BYTE1 13'h117
`define OFS_MONITOR_RESULT_A_BYTE2 13'h118
`define OFS_MONITOR_RESULT_B_BYTE0 13'h119
`define OFS_MONITOR_RESULT_B_BYTE1 13'h11a
`define OFS_MONITOR_RESULT_B_BYTE2 13'h11b
`define OFS_OSCILLATOR_CONTROL 13'h11d
`define OFS_OSCILLATOR_FREQ_BYTE0 13'h11e
`define OFS_OSCILLATOR_FREQ_BYTE1 13'h11f
`define OFS_OSCILLATOR_FREQ_BYTE2 13'h120
`define OFS_OSCILLATOR_FREQ_BYTE3 13'h121
`define OFS_OSCILLATOR_PHASE_BYTE0 13'h122
`define OFS_OSCILLATOR_PHASE_BYTE1 13'h123

// ****************************************************************
// sync gate control fields
// ****************************************************************
`define SYNC_MASTER_BIT 0
`define SYNC_DIVIDER_EN_BIT 1
`define SYNC_DIVIDER_ONCE_BIT 2
`define SYNC_OSC_EN_BIT 3
`define SYNC_OSC_ONCE_BIT 4
`define SYNC_HB_EN_BIT 5
`define SYNC_HB_ONCE_BIT 6
`define SYNC_MONITOR_EN_BIT 7

// ****************************************************************
// mixer, filter and oscillator fields
// ****************************************************************
`define MIX_SYNC_EN_BIT 0
`define MIX_SYNC_ONCE_BIT 1
`define MIX_START_LSB 4
`define MIX_START_MSB 5
`define MIX_WRITE_MASK 8'h33
`define FIR_ENABLE_BIT 0
`define FIR_COMPLEX_BIT 1
`define FIR_MIX_DISABLE_BIT 2
`define FIR_GAIN_ONE_BIT 3
`define FIR_WRITE_MASK 8'h0f
`define HB_HIGHPASS_BIT 1
`define HB_REVERSE_BIT 2
`define HB_ALT_PHASE_BIT 3
`define HB_WRITE_MASK 8'h0e
`define HB_READ_ONE_MASK 8'h01
`define OSC_ENABLE_BIT 0
`define OSC_AMP_DITHER_BIT 1
`define OSC_PHASE_DITHER_BIT 2
`define OSC_WRITE_MASK 8'h07

// ****************************************************************
// reset values and limits
// ****************************************************************
`define RST_SYNC_GATE_CONTROL 8'h00
`define RST_MIXER_CONTROL 8'h00
`define RST_FILTER_OUTPUT_MODE 8'h00
`define RST_HALFBAND_CONTROL 8'h00
`define RST_MONITOR_PERIOD 24'h000080
`define RST_OSCILLATOR_CONTROL 8'h00
`define RST_OSCILLATOR_FREQ 32'h00000000
`define RST_OSCILLATOR_PHASE 16'h0000
`define MONITOR_PERIOD_MIN 24'h000080

`endif

// file: design/ddc_sync_pkg.sv
package ddc_sync_pkg;
  typedef logic [12:0] reg_addr_t;
  typedef logic [7:0] reg_byte_t;
  typedef logic [19:0] monitor_result_t;
  typedef logic [23:0] monitor_period_t;
endpackage : ddc_sync_pkg

// file: design/sync_edge_detect.sv
`timescale 1ns/100ps
`default_nettype none

module sync_edge_detect (
  input wire logic mclk,
  input wire logic reset,
  input wire logic pin_in,
  output logic rise_pulse
);
  logic meta;
  logic stable;
  logic stable_d;

  // ****************************************************************
  // two-stage synchroniser, then edge compare on settled copies only
  // ****************************************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      meta <= 1'b0;
      stable <= 1'b0;
      stable_d <= 1'b0;
    end else begin
      meta <= pin_in;
      stable <= meta;
      stable_d <= stable;
    end
  end

  // one strobe per rising edge, however long the pin stays high
  assign rise_pulse = stable & ~stable_d;
endmodule : sync_edge_detect

`default_nettype wire

// file: design/ddc_sync_and_control_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "ddc_sync_consts.svh"

module ddc_sync_and_control_regs
  import ddc_sync_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic sync_pin,
  input wire reg_addr_t reg_addr,
  input wire reg_byte_t reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output reg_byte_t reg_rdata,
  output logic reg_rvalid,
  input wire monitor_result_t monitor_result_a,
  input wire monitor_result_t monitor_result_b,
  output logic monitor_sync,
  output monitor_period_t monitor_period,
  output logic halfband_sync,
  output logic halfband_alt_phase,
  output logic halfband_highpass,
  output logic halfband_spectral_reverse,
  output logic oscillator_sync,
  output logic oscillator_enable,
  output logic oscillator_amp_dither,
  output logic oscillator_phase_dither,
  output logic [31:0] oscillator_freq,
  output logic [15:0] oscillator_phase,
  output logic divider_sync,
  output logic mixer_sync,
  output logic [1:0] mixer_start_phase,
  output logic mixer_disable,
  output logic complex_mode,
  output logic fir_enable,
  output logic fir_gain_double
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic reg_byte_t byte_of(input logic [31:0] value, input logic [1:0] idx);
    return value[8 * idx +: 8];
  endfunction : byte_of

  function automatic monitor_period_t clamp_period(input monitor_period_t raw);
    return (raw < `MONITOR_PERIOD_MIN) ? `MONITOR_PERIOD_MIN : raw;
  endfunction : clamp_period

  function automatic logic write_hit(input reg_addr_t a, input logic wr, input reg_addr_t ofs);
    return wr && (a == ofs);
  endfunction : write_hit

  // ****************************************************************
  // registers and internal signals
  // ****************************************************************
  reg_byte_t sync_gate_control, mixer_eighth_rate_control, filter_output_mode_control;
  reg_byte_t halfband_filter_control, oscillator_control, next_rdata;
  monitor_period_t monitor_period_raw;
  logic [31:0] oscillator_freq_word;
  logic [15:0] oscillator_phase_word;
  monitor_result_t snap_a, snap_b;
  logic sync_rise, gated_sync;
  logic wr_sync, wr_mix, wr_fir, wr_hb, wr_osc;

  assign wr_sync = write_hit(reg_addr, reg_write, `OFS_SYNC_GATE_CONTROL);
  assign wr_mix = write_hit(reg_addr, reg_write, `OFS_MIXER_EIGHTH_RATE_CONTROL);
  assign wr_fir = write_hit(reg_addr, reg_write, `OFS_FILTER_OUTPUT_MODE_CONTROL);
  assign wr_hb = write_hit(reg_addr, reg_write, `OFS_HALFBAND_FILTER_CONTROL);
  assign wr_osc = write_hit(reg_addr, reg_write, `OFS_OSCILLATOR_CONTROL);

  // ****************************************************************
  // sync pin capture
  // ****************************************************************
  sync_edge_detect u_sync_edge (
    .mclk(mclk),
    .reset(reset),
    .pin_in(sync_pin),
    .rise_pulse(sync_rise)
  );

  // the master bit gates every target, so one gate serves them all
  assign gated_sync = sync_rise & sync_gate_control[`SYNC_MASTER_BIT];

  // ****************************************************************
  // sync gate control: one-shot enables clear themselves
  // ****************************************************************
  // a write beats a same-cycle one-shot clear, so a re-arm is never lost
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync_gate_control <= `RST_SYNC_GATE_CONTROL;
    end else if (wr_sync) begin
      sync_gate_control <= reg_wdata;
    end else begin
      if (gated_sync && sync_gate_control[`SYNC_HB_EN_BIT]
          && sync_gate_control[`SYNC_HB_ONCE_BIT]) begin
        sync_gate_control[`SYNC_HB_EN_BIT] <= 1'b0;
      end
      if (gated_sync && sync_gate_control[`SYNC_OSC_EN_BIT]
          && sync_gate_control[`SYNC_OSC_ONCE_BIT]) begin
        sync_gate_control[`SYNC_OSC_EN_BIT] <= 1'b0;
      end
      if (gated_sync && sync_gate_control[`SYNC_DIVIDER_EN_BIT]
          && sync_gate_control[`SYNC_DIVIDER_ONCE_BIT]) begin
        sync_gate_control[`SYNC_DIVIDER_EN_BIT] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // mixer control
  // ****************************************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mixer_eighth_rate_control <= `RST_MIXER_CONTROL;
    end else if (wr_mix) begin
      mixer_eighth_rate_control <= reg_wdata & `MIX_WRITE_MASK;
    end else if (gated_sync && mixer_eighth_rate_control[`MIX_SYNC_EN_BIT]
                 && mixer_eighth_rate_control[`MIX_SYNC_ONCE_BIT]) begin
      // clearing the master bit here would silence every other target
      mixer_eighth_rate_control[`MIX_SYNC_EN_BIT] <= 1'b0;
    end
  end

  // ****************************************************************
  // filter and half-band control
  // ****************************************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      filter_output_mode_control <= `RST_FILTER_OUTPUT_MODE;
    end else if (wr_fir) begin
      filter_output_mode_control <= reg_wdata & `FIR_WRITE_MASK;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      halfband_filter_control <= `RST_HALFBAND_CONTROL;
    end else if (wr_hb) begin
      halfband_filter_control <= reg_wdata & `HB_WRITE_MASK;
    end
  end

  // ****************************************************************
  // monitor period
  // ****************************************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      monitor_period_raw <= `RST_MONITOR_PERIOD;
    end else if (write_hit(reg_addr, reg_write, `OFS_MONITOR_PERIOD_BYTE0)) begin
      monitor_period_raw[7:0] <= reg_wdata;
    end else if (write_hit(reg_addr, reg_write, `OFS_MONITOR_PERIOD_BYTE1)) begin
      monitor_period_raw[15:8] <= reg_wdata;
    end else if (write_hit(reg_addr, reg_write, `OFS_MONITOR_PERIOD_BYTE2)) begin
      monitor_period_raw[23:16] <= reg_wdata;
    end
  end

  // ****************************************************************
  // oscillator words
  // ****************************************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      oscillator_control <= `RST_OSCILLATOR_CONTROL;
    end else if (wr_osc) begin
      oscillator_control <= reg_wdata & `OSC_WRITE_MASK;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      oscillator_freq_word <= `RST_OSCILLATOR_FREQ;
    end else if (write_hit(reg_addr, reg_write, `OFS_OSCILLATOR_FREQ_BYTE0)) begin
      oscillator_freq_word[7:0] <= reg_wdata;
    end else if (write_hit(reg_addr, reg_write, `OFS_OSCILLATOR_FREQ_BYTE1)) begin
      oscillator_freq_word[15:8] <= reg_wdata;
    end else if (write_hit(reg_addr, reg_write, `OFS_OSCILLATOR_FREQ_BYTE2)) begin
      oscillator_freq_word[23:16] <= reg_wdata;
    end else if (write_hit(reg_addr, reg_write, `OFS_OSCILLATOR_FREQ_BYTE3)) begin
      oscillator_freq_word[31:24] <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      oscillator_phase_word <= `RST_OSCILLATOR_PHASE;
    end else if (write_hit(reg_addr, reg_write, `OFS_OSCILLATOR_PHASE_BYTE0)) begin
      oscillator_phase_word[7:0] <= reg_wdata;
    end else if (write_hit(reg_addr, reg_write, `OFS_OSCILLATOR_PHASE_BYTE1)) begin
      oscillator_phase_word[15:8] <= reg_wdata;
    end
  end

  // ****************************************************************
  // monitor result snapshots
  // ****************************************************************
  // a low-byte read freezes the upper bytes for a consistent word
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      snap_a <= 20'h00000;
      snap_b <= 20'h00000;
    end else begin
      if (reg_read && reg_addr == `OFS_MONITOR_RESULT_A_BYTE0) begin
        snap_a <= monitor_result_a;
      end
      if (reg_read && reg_addr == `OFS_MONITOR_RESULT_B_BYTE0) begin
        snap_b <= monitor_result_b;
      end
    end
  end

  // ****************************************************************
  // read decode
  // ****************************************************************
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr == `OFS_SYNC_GATE_CONTROL) begin
      next_rdata = sync_gate_control;
    end else if (reg_addr == `OFS_MIXER_EIGHTH_RATE_CONTROL) begin
      next_rdata = mixer_eighth_rate_control;
    end else if (reg_addr == `OFS_FILTER_OUTPUT_MODE_CONTROL) begin
      next_rdata = filter_output_mode_control;
    end else if (reg_addr == `OFS_HALFBAND_FILTER_CONTROL) begin
      next_rdata = halfband_filter_control | `HB_READ_ONE_MASK;
    end else if (reg_addr == `OFS_MONITOR_PERIOD_BYTE0) begin
      next_rdata = monitor_period_raw[7:0];
    end else if (reg_addr == `OFS_MONITOR_PERIOD_BYTE1) begin
      next_rdata = monitor_period_raw[15:8];
    end else if (reg_addr == `OFS_MONITOR_PERIOD_BYTE2) begin
      next_rdata = monitor_period_raw[23:16];
    end else if (reg_addr == `OFS_MONITOR_RESULT_A_BYTE0) begin
      next_rdata = monitor_result_a[7:0];
    end else if (reg_addr == `OFS_MONITOR_RESULT_A_BYTE1) begin
      next_rdata = byte_of({12'h000, snap_a}, 2'd1);
    end else if (reg_addr == `OFS_MONITOR_RESULT_A_BYTE2) begin
      next_rdata = byte_of({12'h000, snap_a}, 2'd2);
    end else if (reg_addr == `OFS_MONITOR_RESULT_B_BYTE0) begin
      next_rdata = monitor_result_b[7:0];
    end else if (reg_addr == `OFS_MONITOR_RESULT_B_BYTE1) begin
      next_rdata = byte_of({12'h000, snap_b}, 2'd1);
    end else if (reg_addr == `OFS_MONITOR_RESULT_B_BYTE2) begin
      next_rdata = byte_of({12'h000, snap_b}, 2'd2);
    end else if (reg_addr == `OFS_OSCILLATOR_CONTROL) begin
      next_rdata = oscillator_control;
    end else if (reg_addr == `OFS_OSCILLATOR_FREQ_BYTE0) begin
      next_rdata = byte_of(oscillator_freq_word, 2'd0);
    end else if (reg_addr == `OFS_OSCILLATOR_FREQ_BYTE1) begin
      next_rdata = byte_of(oscillator_freq_word, 2'd1);
    end else if (reg_addr == `OFS_OSCILLATOR_FREQ_BYTE2) begin
      next_rdata = byte_of(oscillator_freq_word, 2'd2);
    end else if (reg_addr == `OFS_OSCILLATOR_FREQ_BYTE3) begin
      next_rdata = byte_of(oscillator_freq_word, 2'd3);
    end else if (reg_addr == `OFS_OSCILLATOR_PHASE_BYTE0) begin
      next_rdata = oscillator_phase_word[7:0];
    end else if (reg_addr == `OFS_OSCILLATOR_PHASE_BYTE1) begin
      next_rdata = oscillator_phase_word[15:8];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (reg_read) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ****************************************************************
  // target sync strobes
  // ****************************************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      monitor_sync <= 1'b0;
      halfband_sync <= 1'b0;
      oscillator_sync <= 1'b0;
      divider_sync <= 1'b0;
      mixer_sync <= 1'b0;
    end else begin
      monitor_sync <= gated_sync & sync_gate_control[`SYNC_MONITOR_EN_BIT];
      halfband_sync <= gated_sync & sync_gate_control[`SYNC_HB_EN_BIT];
      oscillator_sync <= gated_sync & sync_gate_control[`SYNC_OSC_EN_BIT];
      divider_sync <= gated_sync & sync_gate_control[`SYNC_DIVIDER_EN_BIT];
      mixer_sync <= gated_sync & mixer_eighth_rate_control[`MIX_SYNC_EN_BIT];
    end
  end

  // ****************************************************************
  // configuration outputs
  // ****************************************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      halfband_alt_phase <= 1'b0;
      halfband_highpass <= 1'b0;
      halfband_spectral_reverse <= 1'b0;
      mixer_start_phase <= 2'b00;
      mixer_disable <= 1'b0;
      complex_mode <= 1'b0;
      fir_enable <= 1'b0;
      fir_gain_double <= 1'b0;
      monitor_period <= `RST_MONITOR_PERIOD;
    end else begin
      halfband_alt_phase <= halfband_filter_control[`HB_ALT_PHASE_BIT];
      halfband_highpass <= halfband_filter_control[`HB_HIGHPASS_BIT];
      halfband_spectral_reverse <= halfband_filter_control[`HB_REVERSE_BIT];
      mixer_start_phase <=
        mixer_eighth_rate_control[`MIX_START_MSB:`MIX_START_LSB];
      mixer_disable <= filter_output_mode_control[`FIR_MIX_DISABLE_BIT];
      complex_mode <= filter_output_mode_control[`FIR_COMPLEX_BIT];
      fir_enable <= filter_output_mode_control[`FIR_ENABLE_BIT];
      // gain only matters while the fir path is in use
      fir_gain_double <= filter_output_mode_control[`FIR_ENABLE_BIT]
                         & ~filter_output_mode_control[`FIR_GAIN_ONE_BIT];
      monitor_period <= clamp_period(monitor_period_raw);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      oscillator_enable <= 1'b0;
      oscillator_amp_dither <= 1'b0;
      oscillator_phase_dither <= 1'b0;
      oscillator_freq <= `RST_OSCILLATOR_FREQ;
      oscillator_phase <= `RST_OSCILLATOR_PHASE;
    end else begin
      oscillator_enable <= oscillator_control[`OSC_ENABLE_BIT];
      oscillator_amp_dither <= oscillator_control[`OSC_AMP_DITHER_BIT];
      oscillator_phase_dither <= oscillator_control[`OSC_PHASE_DITHER_BIT];
      oscillator_freq <= oscillator_freq_word;
      oscillator_phase <= oscillator_phase_word;
    end
  end

endmodule : ddc_sync_and_control_regs

`default_nettype wire

// file: tb/ddc_sync_and_control_regs_properties.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// sync gating and config checker
// ****************************************************************
module ddc_sync_checker
  import ddc_sync_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic sync_pin,
  input wire reg_addr_t reg_addr,
  input wire reg_byte_t reg_wdata,
  input wire logic reg_write,
  input wire logic monitor_sync,
  input wire monitor_period_t monitor_period,
  input wire logic halfband_sync,
  input wire logic halfband_alt_phase,
  input wire logic oscillator_sync,
  input wire logic divider_sync,
  input wire logic mixer_sync,
  input wire logic [1:0] mixer_start_phase,
  input wire logic fir_gain_double
);
  logic pin_d;
  logic [7:0] sh;
  logic [7:0] mx;
  logic [3:0] fired;
  wire logic pin_rise = sync_pin && !pin_d;
  wire logic [3:0] sv = {mixer_sync, halfband_sync, oscillator_sync, divider_sync};
  wire logic [4:0] all = {monitor_sync, sv};
  wire logic wr_sync = reg_write && reg_addr == 13'h100;
  wire logic wr_mix = reg_write && reg_addr == 13'h101;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) pin_d <= 1'b0;
    else pin_d <= sync_pin;
  end

  // shadows see writes only; one-shot clears live in fired
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) sh <= 8'h00;
    else if (wr_sync) sh <= reg_wdata;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) mx <= 8'h00;
    else if (wr_mix) mx <= reg_wdata;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fired <= 4'h0;
    end else begin
      if (wr_sync) fired[2:0] <= 3'h0;
      else fired[2:0] <= fired[2:0] | (sv[2:0] & {sh[6], sh[4], sh[2]});
      if (wr_mix) fired[3] <= 1'b0;
      else if (mixer_sync && mx[1]) fired[3] <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_go(en);
    pin_rise && sh[0] && en;
  endsequence

  property p_master; all != 5'h00 |-> sh[0]; endproperty
  property p_mon; s_go(sh[7]) |-> ##[2:4] monitor_sync; endproperty
  property p_hb; s_go(sh[5] && !sh[6]) |-> ##[2:4] halfband_sync; endproperty
  property p_osc; s_go(sh[3] && !sh[4]) |-> ##[2:4] oscillator_sync; endproperty
  property p_div; s_go(sh[1] && !sh[2]) |-> ##[2:4] divider_sync; endproperty
  property p_mix; s_go(mx[0] && !mx[1]) |-> ##[2:4] mixer_sync; endproperty
  property p_once; sv != 4'h0 |-> (sv & fired) == 4'h0; endproperty
  property p_phase; wr_mix |=> ##1 mixer_start_phase == $past(reg_wdata[5:4], 2); endproperty
  property p_gain;
    reg_write && reg_addr == 13'h102 |=> ##1
      fir_gain_double == ($past(reg_wdata[0], 2) && !$past(reg_wdata[3], 2));
  endproperty
  property p_period; monitor_period >= 24'h000080; endproperty
  property p_alt;
    reg_write && reg_addr == 13'h103 |=> ##1 halfband_alt_phase == $past(reg_wdata[3], 2);
  endproperty
  property p_single; all != 5'h00 |=> (all & $past(all)) == 5'h00; endproperty

  a_master: assert property (p_master) else $error("strobe without master");
  a_mon: assert property (p_mon) else $error("monitor sync missing");
  a_hb: assert property (p_hb) else $error("half-band sync missing");
  a_osc: assert property (p_osc) else $error("oscillator sync missing");
  a_div: assert property (p_div) else $error("divider sync missing");
  a_mix: assert property (p_mix) else $error("mixer sync missing");
  a_once: assert property (p_once) else $error("one-shot fired twice");
  a_phase: assert property (p_phase) else $error("start phase wrong");
  a_gain: assert property (p_gain) else $error("gain setting wrong");
  a_period: assert property (p_period) else $error("period below floor");
  a_alt: assert property (p_alt) else $error("decimation phase wrong");
  a_single: assert property (p_single) else $error("strobe longer than one");
endmodule : ddc_sync_checker

bind ddc_sync_and_control_regs ddc_sync_checker chk_u (.*);

`default_nettype wire

// file: tb/sync_source_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// external sync pulse source
// ****************************************************************
module sync_source_model (
  input wire logic mclk,
  output logic sync_pin
);
  initial sync_pin = 1'b0;

  // two low cycles keep pulses apart
  task automatic pulse(input int hi);
    repeat (hi) begin
      @(posedge mclk);
      sync_pin <= 1'b1;
    end
    repeat (2) begin
      @(posedge mclk);
      sync_pin <= 1'b0;
    end
  endtask : pulse
endmodule : sync_source_model

`default_nettype wire

// file: tb/ddc_sync_and_control_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, msg) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("unexpected at %0t: %s", $time, msg); \
    end \
  end

module ddc_sync_and_control_regs_tb_top;
  import ddc_sync_pkg::*;
  int err_count = 0;
  int checks = 0;
  int seed = 48712;
  int cnt[5] = '{default: 0};
  logic mclk, reset, sync_pin, reg_write, reg_read, reg_rvalid;
  logic monitor_sync, halfband_sync, oscillator_sync, divider_sync, mixer_sync;
  logic halfband_alt_phase, fir_gain_double;
  logic [1:0] mixer_start_phase;
  logic [7:0] cfg;
  logic [31:0] oscillator_freq;
  logic [15:0] oscillator_phase;
  reg_addr_t reg_addr;
  reg_byte_t reg_wdata, reg_rdata;
  monitor_result_t monitor_result_a, monitor_result_b;
  monitor_period_t monitor_period;
  reg_byte_t mir[int];
  reg_addr_t addrs[14] = '{13'h100, 13'h101, 13'h102, 13'h103, 13'h113, 13'h114, 13'h115,
                           13'h11d, 13'h11e, 13'h11f, 13'h120, 13'h121, 13'h122, 13'h123};

  sync_source_model src_u (.mclk, .sync_pin);

  ddc_sync_and_control_regs dut_u (
    .mclk, .reset, .sync_pin, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .reg_rvalid, .monitor_result_a, .monitor_result_b, .monitor_sync,
    .monitor_period, .halfband_sync, .halfband_alt_phase, .halfband_highpass(cfg[3]),
    .halfband_spectral_reverse(cfg[4]), .oscillator_sync, .oscillator_enable(cfg[5]),
    .oscillator_amp_dither(cfg[6]), .oscillator_phase_dither(cfg[7]), .oscillator_freq,
    .oscillator_phase, .divider_sync, .mixer_sync, .mixer_start_phase,
    .mixer_disable(cfg[2]), .complex_mode(cfg[1]), .fir_enable(cfg[0]), .fir_gain_double
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cnt[0] += monitor_sync;
    cnt[1] += halfband_sync;
    cnt[2] += oscillator_sync;
    cnt[3] += divider_sync;
    cnt[4] += mixer_sync;
  end

  // ****************************************************************
  // expectations and bus tasks
  // ****************************************************************
  function automatic reg_byte_t exp_rd(input reg_addr_t a, input reg_byte_t d);
    case (a)
      13'h101: return d & 8'h33;
      13'h102: return d & 8'h0f;
      13'h103: return (d & 8'h0e) | 8'h01;
      13'h11d: return d & 8'h07;
      default: return d;
    endcase
  endfunction : exp_rd

  function automatic logic [1:0] one(input logic en, input logic once, input logic [1:0] k);
    return !en ? 2'd0 : (once ? 2'd1 : k);
  endfunction : one

  function automatic logic [9:0] cexp(input reg_byte_t c, input reg_byte_t m, input int n);
    logic [1:0] k;
    k = 2'(n);
    if (!c[0]) return 10'h000;
    return {one(m[0], m[1], k), one(c[1], c[2], k), one(c[3], c[4], k),
            one(c[5], c[6], k), c[7] ? k : 2'd0};
  endfunction : cexp

  task automatic end_sim;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd_chk(input reg_addr_t a, input reg_byte_t e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    @(negedge mclk);
    `CHK(reg_rvalid, 1'b1, "rvalid")
    `CHK(reg_rdata, e, "read data")
    @(posedge mclk);
  endtask : rd_chk

  task automatic sync_run(input reg_byte_t c, input reg_byte_t m, input int n,
                          input logic [9:0] e);
    int b[5];
    wr(13'h100, c);
    wr(13'h101, m);
    b = cnt;
    repeat (n) src_u.pulse(1 + ($random(seed) & 1));
    repeat (6) @(posedge mclk);
    for (int i = 0; i < 5; i++) begin
      `CHK(cnt[i] - b[i], int'(e[2 * i +: 2]), "strobe count")
    end
  endtask : sync_run

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    monitor_result_t v;
    reg_byte_t c8, m8;
    int n;
    reset = 1'b1;
    {reg_write, reg_read, reg_addr, reg_wdata} = '0;
    monitor_result_a = '0;
    monitor_result_b = '0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    foreach (addrs[i]) rd_chk(addrs[i], exp_rd(addrs[i], (addrs[i] == 13'h113) ? 8'h80 : 8'h00));
    foreach (addrs[i]) begin
      mir[addrs[i]] = 8'($random(seed));
      wr(addrs[i], mir[addrs[i]]);
    end
    foreach (addrs[i]) rd_chk(addrs[i], exp_rd(addrs[i], mir[addrs[i]]));
    `CHK(mixer_start_phase, mir[13'h101][5:4], "start phase")
    `CHK(fir_gain_double, mir[13'h102][0] & ~mir[13'h102][3], "gain")
    `CHK(halfband_alt_phase, mir[13'h103][3], "alt phase")
    `CHK(cfg, {mir[13'h11d][2:0], mir[13'h103][2:1], mir[13'h102][2:0]}, "cfg")
    `CHK(oscillator_freq, {mir[13'h121], mir[13'h120], mir[13'h11f], mir[13'h11e]}, "freq")
    `CHK(oscillator_phase, {mir[13'h123], mir[13'h122]}, "phase")
    wr(13'h113, 8'h7f);
    wr(13'h114, 8'h00);
    wr(13'h115, 8'h00);
    rd_chk(13'h113, 8'h7f);
    `CHK(monitor_period, 24'h000080, "period floor")
    wr(13'h124, 8'hff);
    rd_chk(13'h124, 8'h00);
    monitor_result_a <= 20'($random(seed));
    monitor_result_b <= 20'($random(seed));
    wr(13'h116, 8'hff);
    for (int c = 0; c < 2; c++) begin
      v = c ? monitor_result_b : monitor_result_a;
      rd_chk(13'h116 + 13'(3 * c), v[7:0]);
      rd_chk(13'h117 + 13'(3 * c), v[15:8]);
      rd_chk(13'h118 + 13'(3 * c), {4'h0, v[19:16]});
    end
    sync_run(8'hfe, 8'h31, 2, 10'h000);
    sync_run(8'h7f, 8'h03, 2, 10'h154);
    rd_chk(13'h100, 8'h55);
    rd_chk(13'h101, 8'h02);
    sync_run(8'hab, 8'h31, 3, 10'h3ff);
    repeat (8) begin
      c8 = 8'($random(seed));
      m8 = 8'($random(seed)) & 8'h33;
      n = 1 + int'({$random(seed)} % 3);
      sync_run(c8, m8, n, cexp(c8, m8, n));
    end
    end_sim();
  end
endmodule : ddc_sync_and_control_regs_tb_top

`default_nettype wire
